// ===== tick_pkg.sv
/*
  Shared constants for the core tick timer: register map, field
  positions, reset values and the address-match helper.
  Assumes software reaches the block with whole 32-bit words on a
  32-bit byte address inside the private peripheral region.
*/
`default_nettype none

package tick_pkg;

  // Private peripheral region and register offsets within it
  localparam logic [31:0] PRIV_PERIPH_BASE  = 32'he000_0000;
  localparam logic [15:0] OFS_CTRL_STATUS   = 16'he010;
  localparam logic [15:0] OFS_RELOAD_VALUE  = 16'he014;
  localparam logic [15:0] OFS_CURRENT_VALUE = 16'he018;
  localparam logic [15:0] OFS_CALIBRATION   = 16'he01c;

  // Control and status field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 1;
  localparam int CTRL_SRC_BIT    = 2;
  localparam int CTRL_WRAP_BIT   = 16;

  // Calibration field positions
  localparam int CAL_NO_REF_CLOCK_BIT   = 31;
  localparam int CAL_SKEW_BIT    = 30;

  // Counter width and reset values
  localparam int CNT_W = 24;
  typedef logic [CNT_W-1:0] count_t;
  typedef logic [31:0]      word_t;
  localparam count_t CNT_ZERO        = 24'h00_0000;
  localparam count_t CNT_ONE         = 24'h00_0001;
  localparam count_t RELOAD_RESET    = 24'h00_0000;
  localparam logic   CTRL_BIT_RESET  = 1'b0;
  localparam word_t  RDATA_IDLE      = 32'h0000_0000;

  // Calibration defaults for the top-level parameters
  localparam logic   CAL_NO_REF_CLOCK_DEF   = 1'b0;
  localparam logic   CAL_SKEW_DEF    = 1'b0;
  localparam count_t CAL_TENMS_DEF   = 24'h00_0000;

  // Full-address match against one register offset
  function automatic logic addr_hit(input word_t addr, input logic [15:0] ofs);
    addr_hit = (addr == (PRIV_PERIPH_BASE | {16'h0000, ofs}));
  endfunction

endpackage

`default_nettype wire

// ===== tick_down_counter.sv
/*
  24-bit down-counter with reload on zero and a wrap pulse on the
  step from one to zero.
  Assumes the caller qualifies count_step with the clock enable.
*/
`default_nettype none

module tick_down_counter
(
  input  wire  logic           clk_sys,
  input  wire  logic           rst_n,
  input  wire  logic           clk_en,
  input  wire  logic           count_step,
  input  wire  logic           count_clear,
  input  wire  tick_pkg::count_t reload_val,
  output var   tick_pkg::count_t count_val,
  output logic                 wrap_pulse
);
  import tick_pkg::*;

  count_t count_reg;
  count_t count_next;
  logic   at_zero;
  logic   at_one;

  // Zero and one detection for reload and wrap
  assign at_zero    = (count_reg == CNT_ZERO);
  assign at_one     = (count_reg == CNT_ONE);
  assign wrap_pulse = count_step && !count_clear && at_one;
  assign count_val  = count_reg;

  // Clear beats counting so a write never races a reload
  always_comb
  begin
    count_next = count_reg;
    if (count_clear)
      count_next = CNT_ZERO;
    else if (count_step && at_zero)
      count_next = reload_val;
    else if (count_step)
      count_next = count_reg - CNT_ONE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      count_reg <= CNT_ZERO;
    else if (clk_en)
      count_reg <= count_next;
  end

endmodule

`default_nettype wire

// ===== tick_sticky_flag.sv
/*
  Sticky event flag: set by hardware, cleared by a software action.
  Assumes set and clear arrive as single-cycle strobes.
*/
`default_nettype none

module tick_sticky_flag
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic flag_set,
  input  wire logic flag_clear,
  output var  logic flag_out
);
  import tick_pkg::*;

  logic flag_reg;
  logic flag_next;

  // Set wins so a wrap in the clearing cycle is never lost
  assign flag_next = flag_set | (flag_reg & ~flag_clear);
  assign flag_out  = flag_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      flag_reg <= CTRL_BIT_RESET;
    else if (clk_en)
      flag_reg <= flag_next;
  end

endmodule

`default_nettype wire

// ===== core_tick_timer.sv
/*
  Core tick timer: a 24-bit down-counter with reload, a sticky wrap
  flag, and a tick exception request toward the nested interrupt
  controller, reached through four word-wide registers.
  Assumes a plain register port (address, write data, write and read
  strobes, read data one cycle later), a microsecond enable pulse
  from the watchdog block synchronous to clk_sys, and a controller
  that owns the enable, pending and priority state of the request.
*/
// Design decision made here: strobed register access.
`default_nettype none

// How it works
// RULE1: The counter and its reload value are both 24 bits wide.
// RULE2: With the reference source selected, counting waits for the microsecond pulse.
// RULE3: With the processor source selected, counting happens every clock.
// RULE4: Control bit 2 picks the source, 0 reference and 1 processor clock, reset 0.
// RULE5: Without a reference clock the source bit always reads as 1.
// RULE6: Control bit 16 reads 1 if the counter hit zero since the last read.
// RULE7: Any read of the control register clears bit 16 after returning it.
// RULE8: Control bit 1 lets a count to zero raise the tick exception request.
// RULE9: Control bit 0 enables the counter, reset 0.
// RULE10: The request is its own interrupt source with a priority set elsewhere.
// RULE11: Registers sit at 0xe010 to 0xe01c above the private peripheral base.
// RULE12: After reaching zero the next count loads the reload value; zero reload stays at zero.
// RULE13: Only the step from one to zero sets the flag and the request.
// RULE14: Any write to the current value clears it and the wrap flag.
// RULE15: Calibration bit 31 reports no reference clock and forces the source bit to 1.
// RULE16: Enabled, the counter drops by one per count event; disabled, it holds.
// RULE17: Software uses whole-word accesses and writes reserved bits as zero.

module core_tick_timer
#(
  parameter logic             NO_REF_CLOCK = tick_pkg::CAL_NO_REF_CLOCK_DEF,
  parameter logic             CAL_SKEW     = tick_pkg::CAL_SKEW_DEF,
  parameter tick_pkg::count_t CAL_TENMS    = tick_pkg::CAL_TENMS_DEF
)
(
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire logic          ref_tick_pulse,
  input  wire tick_pkg::word_t bus_addr,
  input  wire tick_pkg::word_t bus_wdata,
  input  wire logic          bus_wr,
  input  wire logic          bus_rd,
  output var  tick_pkg::word_t bus_rdata,
  output var  logic          tick_irq_req
);
  import tick_pkg::*;

  // Stored control bits and reload value
  logic   enable_reg;
  logic   enable_next;
  logic   irq_en_reg;
  logic   irq_en_next;
  logic   src_sel_reg;
  logic   src_sel_next;
  count_t reload_reg;
  count_t reload_next;
  word_t  rdata_reg;
  word_t  rdata_next;
  logic   irq_req_reg;
  logic   irq_req_next;

  // Address decode results
  logic hit_ctrl;
  logic hit_reload;
  logic hit_current;
  logic hit_calib;
  logic hit_any;

  // Qualified register accesses
  logic ctrl_wr;
  logic ctrl_rd;
  logic reload_wr;
  logic current_wr;

  // Counter and flag connections
  logic   src_sel_eff;
  logic   count_step;
  count_t count_val;
  logic   wrap_pulse;
  logic   wrap_seen_flag;

  // Read views of each register
  word_t ctrl_view;
  word_t reload_view;
  word_t current_view;
  word_t calib_view;

  // Full-address decode of the four registers
  assign hit_ctrl    = addr_hit(bus_addr, OFS_CTRL_STATUS);   // see RULE11
  assign hit_reload  = addr_hit(bus_addr, OFS_RELOAD_VALUE);  // see RULE11
  assign hit_current = addr_hit(bus_addr, OFS_CURRENT_VALUE); // see RULE11
  assign hit_calib   = addr_hit(bus_addr, OFS_CALIBRATION);   // see RULE11
  assign hit_any     = hit_ctrl | hit_reload | hit_current | hit_calib;

  // Strobes qualified by the decode; unmapped writes do nothing
  assign ctrl_wr    = bus_wr & hit_ctrl;
  assign ctrl_rd    = bus_rd & hit_ctrl;
  assign reload_wr  = bus_wr & hit_reload;
  assign current_wr = bus_wr & hit_current;

  // Missing reference forces the processor clock source
  assign src_sel_eff = src_sel_reg | NO_REF_CLOCK; // see RULE5, RULE15

  // One count event per pulse or per clock, only while enabled
  assign count_step = clk_en & enable_reg
                    & (src_sel_eff | ref_tick_pulse); // see RULE2, RULE3, RULE9, RULE16

  // Control bits take new values only on a control write
  assign enable_next  = ctrl_wr ? bus_wdata[CTRL_ENABLE_BIT] : enable_reg; // see RULE9
  assign irq_en_next  = ctrl_wr ? bus_wdata[CTRL_IRQ_EN_BIT] : irq_en_reg; // see RULE8
  assign src_sel_next = ctrl_wr ? bus_wdata[CTRL_SRC_BIT]    : src_sel_reg; // see RULE4

  // Upper write bits are dropped so reload stays in range
  assign reload_next = reload_wr ? bus_wdata[CNT_W-1:0] : reload_reg; // see RULE1

  // Request pulse follows the one-to-zero step when enabled
  assign irq_req_next = wrap_pulse & irq_en_reg; // see RULE8, RULE13

  // Control and status view; reserved bits read zero
  always_comb
  begin
    ctrl_view                 = RDATA_IDLE;
    ctrl_view[CTRL_ENABLE_BIT] = enable_reg;
    ctrl_view[CTRL_IRQ_EN_BIT] = irq_en_reg;
    ctrl_view[CTRL_SRC_BIT]    = src_sel_eff;    // see RULE5
    ctrl_view[CTRL_WRAP_BIT]   = wrap_seen_flag; // see RULE6
  end

  // Counter-wide views; bits above 23 read zero
  assign reload_view  = {8'h00, reload_reg};  // see RULE1
  assign current_view = {8'h00, count_val};   // see RULE1

  // Calibration view from fixed parameters
  always_comb
  begin
    calib_view                = {8'h00, CAL_TENMS};
    calib_view[CAL_NO_REF_CLOCK_BIT] = NO_REF_CLOCK; // see RULE15
    calib_view[CAL_SKEW_BIT]  = CAL_SKEW;
  end

  // Read mux; the data stand for one enabled cycle, zero otherwise
  always_comb
  begin
    rdata_next = RDATA_IDLE;
    if (!bus_rd || !hit_any)
      rdata_next = RDATA_IDLE;
    else if (hit_ctrl)
      rdata_next = ctrl_view;
    else if (hit_reload)
      rdata_next = reload_view;
    else if (hit_current)
      rdata_next = current_view;
    else if (hit_calib)
      rdata_next = calib_view;
  end

  // Count engine; a current-value write clears it
  tick_down_counter u_counter
  (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .count_step  (count_step),
    .count_clear (current_wr),  // see RULE14
    .reload_val  (reload_reg),  // see RULE12
    .count_val   (count_val),
    .wrap_pulse  (wrap_pulse)   // see RULE13
  );

  // Wrap flag: cleared by a control read or current-value write
  tick_sticky_flag u_wrap_flag
  (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .flag_set   (wrap_pulse),            // see RULE6, RULE13
    .flag_clear (ctrl_rd | current_wr),  // see RULE7, RULE14
    .flag_out   (wrap_seen_flag)
  );

  // Control bits, with the documented reset state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      enable_reg  <= CTRL_BIT_RESET;
      irq_en_reg  <= CTRL_BIT_RESET;
      src_sel_reg <= CTRL_BIT_RESET;
    end
    else if (clk_en)
    begin
      enable_reg  <= enable_next;
      irq_en_reg  <= irq_en_next;
      src_sel_reg <= src_sel_next;
    end
  end

  // Reload value; reset to zero so the count never starts unknown
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      reload_reg <= RELOAD_RESET;
    else if (clk_en)
      reload_reg <= reload_next;
  end

  // Registered read data and exception request
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rdata_reg   <= RDATA_IDLE;
      irq_req_reg <= CTRL_BIT_RESET;
    end
    else if (clk_en)
    begin
      rdata_reg   <= rdata_next;
      irq_req_reg <= irq_req_next;
    end
  end

  // Dedicated request line so the controller can rank it alone
  assign tick_irq_req = irq_req_reg; // see RULE10
  assign bus_rdata    = rdata_reg;

  // Checks on the counter, flag, request and register port
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Reference source: no pulse, no movement
  a_ref_pulse_gate: assert property ( // see RULE2
    (clk_en && enable_reg && !src_sel_eff && !ref_tick_pulse && !current_wr)
      |=> $stable(count_val))
    else $error("counter moved without a reference pulse");

  // Processor source: one down per clock
  a_sysclk_decrement: assert property ( // see RULE3
    (clk_en && enable_reg && src_sel_eff && !current_wr && count_val != CNT_ZERO)
      |=> (count_val == $past(count_val) - CNT_ONE))
    else $error("counter did not drop by one on the processor clock");

  // Reference source: one down per pulse
  a_pulse_decrement: assert property ( // see RULE16
    (clk_en && enable_reg && ref_tick_pulse && !current_wr && count_val != CNT_ZERO)
      |=> (count_val == $past(count_val) - CNT_ONE))
    else $error("counter did not drop by one on a reference pulse");

  // Disabled counter holds
  a_disabled_hold: assert property ( // see RULE9
    (!enable_reg && !current_wr) |=> $stable(count_val))
    else $error("disabled counter changed");

  // Zero reloads on the next count
  a_zero_reload: assert property ( // see RULE12
    (count_step && count_val == CNT_ZERO && !current_wr)
      |=> (count_val == $past(reload_reg)))
    else $error("counter at zero did not load the reload value");

  // Wrap sets the flag in the next cycle
  a_wrap_sets_flag: assert property ( // see RULE13
    (clk_en && count_step && count_val == CNT_ONE && !current_wr)
      |=> wrap_seen_flag)
    else $error("one-to-zero step did not set the wrap flag");

  // Control read returns the flag and then clears it
  a_ctrl_read_clear: assert property ( // see RULE7
    (clk_en && ctrl_rd && !wrap_pulse)
      |=> (bus_rdata[CTRL_WRAP_BIT] == $past(wrap_seen_flag)) && !wrap_seen_flag)
    else $error("control read did not return then clear the wrap flag");

  // Request only after a wrap with the request enabled
  a_irq_gated: assert property ( // see RULE8
    clk_en |=> (tick_irq_req == $past(wrap_pulse && irq_en_reg)))
    else $error("tick request does not match wrap and enable");

  // Current-value write clears count and flag
  a_current_clear: assert property ( // see RULE14
    (clk_en && current_wr) |=> (count_val == CNT_ZERO) && !wrap_seen_flag)
    else $error("current-value write did not clear counter and flag");

  // Source bit reads one without a reference clock
  a_no_ref_clock_source: assert property ( // see RULE5
    (clk_en && ctrl_rd && NO_REF_CLOCK) |=> bus_rdata[CTRL_SRC_BIT])
    else $error("source bit read zero with no reference clock");

  // Reload and current reads keep the top byte zero
  a_width_limit: assert property ( // see RULE1
    (clk_en && bus_rd && (hit_reload || hit_current)) |=> (bus_rdata[31:24] == 8'h00))
    else $error("counter-wide register read above bit 23");

  // Unmapped reads and idle cycles return zero
  a_unmapped_zero: assert property ( // see RULE11
    (clk_en && !(bus_rd && hit_any)) |=> (bus_rdata == RDATA_IDLE))
    else $error("read data not zero for idle or unmapped access");

  // Request is a single pulse; a reload step never follows with a second one
  a_irq_pulse_one: assert property ( // see RULE13
    (clk_en && tick_irq_req)
      |=> !tick_irq_req)
    else $error("tick request stood for more than one enabled cycle");

  // Reloading from zero alone leaves a clear flag clear
  a_reload_no_flag: assert property ( // see RULE13
    (count_step && count_val == CNT_ZERO && !wrap_seen_flag)
      |=> !wrap_seen_flag)
    else $error("reload from zero set the wrap flag");

  // No request while the request gate is off
  a_irq_needs_en: assert property ( // see RULE8
    (clk_en && !irq_en_reg)
      |=> !tick_irq_req)
    else $error("tick request raised with the request gate off");

  // Reset leaves every control bit and the reload at zero
  a_ctrl_reset_state: assert property ( disable iff (1'b0) // see RULE4, RULE9
    !rst_n
      |=> (!enable_reg && !irq_en_reg && !src_sel_reg && reload_reg == RELOAD_RESET))
    else $error("control bits or reload not cleared by reset");

  // A control write lands in the enable bit
  a_ctrl_write_lands: assert property ( // see RULE9
    (clk_en && ctrl_wr)
      |=> (enable_reg == $past(bus_wdata[CTRL_ENABLE_BIT])))
    else $error("control write did not land in the enable bit");

  // A reload write keeps exactly the low 24 bits
  a_reload_write_width: assert property ( // see RULE1
    (clk_en && reload_wr)
      |=> (reload_reg == $past(bus_wdata[CNT_W-1:0])))
    else $error("reload write did not keep the low 24 bits");

  // Once set, the flag stays until a control read or a current write
  a_flag_holds_set: assert property ( // see RULE6
    (wrap_seen_flag && !ctrl_rd && !current_wr)
      |=> wrap_seen_flag)
    else $error("wrap flag dropped without a clearing access");

  // Calibration read reports the missing reference in bit 31
  a_calib_no_ref_clock_bit: assert property ( // see RULE15
    (clk_en && bus_rd && hit_calib)
      |=> (bus_rdata[CAL_NO_REF_CLOCK_BIT] == NO_REF_CLOCK))
    else $error("calibration read gave the wrong reference flag");

endmodule

`default_nettype wire

// ===== tick_irq_sink.sv
/*
  Far-side model of the interrupt controller: counts tick requests.
  Assumes the request is a pulse of one enabled cycle synchronous to clk_sys.
*/
`default_nettype none

module tick_irq_sink
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic tick_irq_req,
  output var  int   req_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic req_prev;

  // Rising edges only: a frozen clock enable holds one request high
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      req_cnt  <= 0;
      req_prev <= 1'b0;
    end
    else
    begin
      req_prev <= (tick_irq_req === 1'b1);
      if (tick_irq_req === 1'b1 && !req_prev)
        req_cnt <= req_cnt + 1;
    end
  end
endmodule

`default_nettype wire

// ===== core_tick_timer_tb_top.sv
/*
  Self-checking bench for the core tick timer: a cycle model checks
  read data and the request at every edge.
  Assumes the register port answers one cycle after the read strobe.
*/
`default_nettype none

module core_tick_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tick_pkg::*;

  localparam word_t A_CTRL = PRIV_PERIPH_BASE | {16'h0000, OFS_CTRL_STATUS};
  localparam word_t A_REL  = PRIV_PERIPH_BASE | {16'h0000, OFS_RELOAD_VALUE};
  localparam word_t A_CUR  = PRIV_PERIPH_BASE | {16'h0000, OFS_CURRENT_VALUE};
  localparam word_t A_CAL  = PRIV_PERIPH_BASE | {16'h0000, OFS_CALIBRATION};
  localparam count_t CAL_T = 24'h01_2345; // Arbitrary calibration pattern

  logic  clk_sys        = 1'b0;
  logic  rst_n          = 1'b0;
  logic  clk_en         = 1'b1;
  logic  ref_tick_pulse = 1'b0;
  word_t bus_addr       = 32'h0000_0000;
  word_t bus_wdata      = 32'h0000_0000;
  logic  bus_wr         = 1'b0;
  logic  bus_rd         = 1'b0;
  word_t rdata_a;
  word_t rdata_b;
  logic  irq_a;
  int    req_cnt;
  int    error_cnt      = 0;
  int    tests_run      = 0;
  bit    jitter         = 1'b0;
  bit    live           = 1'b0;
  int    m_cnt;
  int    m_rel;
  int    m_irqs;
  logic  m_flag;
  logic  m_en;
  logic  m_ie;
  logic  m_src;
  logic  m_irq;
  logic  step;
  logic  wrap;
  word_t m_rd;
  word_t amap [6] = '{A_CTRL, A_REL, A_CUR, A_CAL, 32'he000_e020, 32'hf000_e010};

  core_tick_timer dut_u
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .ref_tick_pulse(ref_tick_pulse),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(rdata_a), .tick_irq_req(irq_a)
  );

  // Same bus, no reference clock: only its calibration word and control word are looked at
  core_tick_timer #(.NO_REF_CLOCK(1'b1), .CAL_SKEW(1'b1), .CAL_TENMS(CAL_T)) dut_no_ref_clock_u
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .ref_tick_pulse(ref_tick_pulse),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(rdata_b), .tick_irq_req()
  );

  tick_irq_sink irq_sink_u
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick_irq_req(irq_a), .req_cnt(req_cnt)
  );

  always #5 clk_sys = ~clk_sys;

  // Random gaps in the enable and random microsecond pulses
  always @(posedge clk_sys)
  begin
    clk_en <= jitter ? ($urandom_range(3) != 0) : 1'b1;
    ref_tick_pulse <= ($urandom_range(2) == 0);
  end

  task automatic chk_word(input word_t got, input word_t exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Whole-word cycles; address and data scrambled once released
  task automatic bus_op(input bit is_wr, input word_t a, input word_t d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= is_wr;
    bus_rd <= !is_wr;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask

  // Cycle model: outputs compared before this edge's update lands
  always @(posedge clk_sys)
  begin
    if (live)
    begin
      chk_word(rdata_a, m_rd);
      chk_bit(irq_a, m_irq);
    end
    if (!rst_n)
    begin
      live = 1'b1;
      {m_cnt, m_rel, m_irqs, m_rd} = '0;
      {m_flag, m_en, m_ie, m_src, m_irq} = '0;
    end
    else if (clk_en)
    begin
      step = m_en && (m_src || ref_tick_pulse);
      wrap = 1'b0;
      m_irq = 1'b0;
      m_rd = '0;
      if (bus_rd)
        m_rd = (bus_addr == A_CTRL) ? {15'h0, m_flag, 13'h0, m_src, m_ie, m_en} :
               (bus_addr == A_REL)  ? word_t'(m_rel) :
               (bus_addr == A_CUR)  ? word_t'(m_cnt) : 32'h0000_0000;
      if (bus_wr && bus_addr == A_CUR)
      begin
        m_cnt = 0;
        m_flag = 1'b0;
      end
      else if (step)
      begin
        if (m_cnt == 1)
          wrap = 1'b1;
        m_cnt = (m_cnt == 0) ? m_rel : m_cnt - 1;
      end
      if (bus_rd && bus_addr == A_CTRL)
        m_flag = 1'b0;
      if (wrap)
      begin
        m_flag = 1'b1;
        m_irq = m_ie;
        m_irqs += int'(m_ie);
      end
      if (bus_wr && bus_addr == A_CTRL)
        {m_src, m_ie, m_en} = bus_wdata[2:0];
      if (bus_wr && bus_addr == A_REL)
        m_rel = int'(bus_wdata[23:0]);
    end
  end

  initial
  begin
    #400000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(25758));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values, calibration and unmapped places, no reference clock
    foreach (amap[i])
      bus_op(1'b0, amap[i], 32'h0000_0000);
    bus_op(1'b0, A_CAL, 32'h0000_0000);
    #1 chk_word(rdata_b, {1'b1, 1'b1, 6'h00, CAL_T});
    bus_op(1'b1, A_CTRL, 32'h0000_0000);
    bus_op(1'b0, A_CTRL, 32'h0000_0000);
    #1 chk_word(rdata_b, 32'h0000_0004);
    // Read-only and unmapped writes are dropped; reserved bits written as zero
    foreach (amap[i])
      bus_op(1'b1, amap[i], (amap[i] == A_CTRL) ? 32'h0000_0000 : 32'h00ff_fff8);
    foreach (amap[i])
      bus_op(1'b0, amap[i], 32'h0000_0000);
    // Short reload on the processor clock, flag polled hard
    bus_op(1'b1, A_REL, 32'h0000_0002);
    bus_op(1'b1, A_CTRL, 32'h0000_0007);
    repeat (12) bus_op(1'b0, A_CTRL, 32'h0000_0000);
    // Reference pulses, then a random mix with enable gaps
    bus_op(1'b1, A_CTRL, 32'h0000_0003);
    repeat (10) bus_op(1'b0, A_CUR, 32'h0000_0000);
    jitter = 1'b1;
    repeat (400)
    begin
      automatic word_t a = amap[$urandom_range(5)];
      automatic word_t d = (a == A_REL)  ? word_t'($urandom_range(4)) :
                           (a == A_CTRL) ? ($urandom & 32'h0000_0007) :
                                           ($urandom & 32'h00ff_ffff);
      bus_op($urandom_range(1), a, d);
    end
    jitter = 1'b0;
    // Stop the counter so the request tally is settled before comparing
    bus_op(1'b1, A_CTRL, 32'h0000_0000);
    bus_op(1'b0, A_CTRL, 32'h0000_0000);
    #1 chk_word(word_t'(req_cnt), word_t'(m_irqs));
    // Second reset in mid-run, launched on a clock edge
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (amap[i])
      bus_op(1'b0, amap[i], 32'h0000_0000);
    report_and_stop();
  end
endmodule

`default_nettype wire
